/* File: serial_port_pkg.sv */
package serial_port_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] ABORT_EDGE = 5'h0F;
   localparam logic [CNT_W-1:0] COMMIT_EDGE = 5'h10;
   localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [2:0] PIN_RST = 3'h3;

   // ----------------------------------------------------------------
   // Frame states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FRAME = 2'b10
   } state_t;

endpackage : serial_port_pkg

/* File: serial_write_port.sv */
`timescale 1ns/1ps
module serial_write_port (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic SCLK,
   input wire logic SYNC_B,
   input wire logic DIN,
   output logic DOUT,
   output logic [serial_port_pkg::WORD_BITS-1:0] WORD,
   output logic UPDATE,
   output logic LOADED
);
   import serial_port_pkg::*;

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   // Bit 0 serial clock, bit 1 frame strobe, bit 2 data.
   // A level counts only once stages two and three agree, which
   // rejects a single sample caught mid-transition.
   logic [2:0] s1_q, s2_q, s3_q, f_q;
   logic [2:0] f_d;
   logic sclk_fall, sync_fall, sync_rise;

   always_comb begin
      f_d = f_q;
      for (int i = 0; i < 3; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            f_d[i] = s2_q[i];
         end
      end
      sclk_fall = f_q[0] & ~f_d[0];
      sync_fall = f_q[1] & ~f_d[1];
      sync_rise = ~f_q[1] & f_d[1];
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         s1_q <= PIN_RST;
         s2_q <= PIN_RST;
         s3_q <= PIN_RST;
         f_q <= PIN_RST;
      end else begin
         s1_q <= {DIN, SYNC_B, SCLK};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= f_d;
      end
   end

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [WORD_BITS-1:0] sreg_q, sreg_d;
   logic [WORD_BITS-1:0] word_q, word_d;
   logic dout_q, dout_d;
   logic upd_q, upd_d;
   logic loaded_q, loaded_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      sreg_d = sreg_q;
      word_d = word_q;
      dout_d = dout_q;
      upd_d = 1'b0;
      loaded_d = loaded_q;
      unique case (state_q)
         ST_IDLE: begin
            dout_d = 1'b0;
            if (sync_fall) begin
               state_d = ST_FRAME;
               cnt_d = CNT_RST;
            end
         end
         ST_FRAME: begin
            if (sync_rise) begin
               state_d = ST_IDLE;
               dout_d = 1'b0;
               // Edge 15 alone is not a full word, so it is dropped too
               if (cnt_q >= COMMIT_EDGE) begin
                  word_d = sreg_q;
                  upd_d = 1'b1;
                  loaded_d = 1'b1;
               end
            end else if (sclk_fall) begin
               sreg_d = {sreg_q[WORD_BITS-2:0], f_d[2]};
               if (cnt_q >= COMMIT_EDGE) begin
                  dout_d = sreg_q[WORD_BITS-1];
               end
               // Saturate: long daisy-chain frames must not wrap to an abort
               if (cnt_q != CNT_MAX) begin
                  cnt_d = CNT_W'(cnt_q + 1'b1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ST_IDLE;
         cnt_q <= CNT_RST;
         sreg_q <= WORD_RST;
         word_q <= WORD_RST;
         dout_q <= 1'b0;
         upd_q <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sreg_q <= sreg_d;
         word_q <= word_d;
         dout_q <= dout_d;
         upd_q <= upd_d;
         loaded_q <= loaded_d;
      end
   end

   assign DOUT = dout_q;
   assign WORD = word_q;
   assign UPDATE = upd_q;
   assign LOADED = loaded_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   shift_in_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sclk_fall && !sync_rise) |=> sreg_q[0] == $past(f_d[2]))
      else $error("serial bit not shifted in");

   commit_word_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sync_rise && cnt_q >= COMMIT_EDGE)
      |=> UPDATE && WORD == $past(sreg_q) ##1 !UPDATE)
      else $error("full frame not committed");

   abort_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sync_rise && cnt_q < ABORT_EDGE) |=> !UPDATE && $stable(WORD))
      else $error("aborted frame changed word");

   chain_quiet_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      DOUT |-> (state_q == ST_FRAME && cnt_q > COMMIT_EDGE))
      else $error("chain output active too early");

   chain_delay_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sclk_fall && !sync_rise && cnt_q >= COMMIT_EDGE)
      |=> DOUT == $past(sreg_q[WORD_BITS-1]))
      else $error("chain output not sixteen edges late");

   word_change_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      !$stable(WORD) |-> UPDATE && LOADED)
      else $error("word changed without commit");

   zero_start_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      !LOADED |-> WORD == WORD_RST)
      else $error("word nonzero before first commit");

   update_pulse_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      UPDATE |=> !UPDATE)
      else $error("update pulse longer than one cycle");

   late_abort_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sync_rise && cnt_q == ABORT_EDGE)
      |=> !UPDATE && $stable(WORD))
      else $error("fifteen edge frame committed");

   frame_end_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sync_rise) |=> state_q == ST_IDLE && !DOUT)
      else $error("frame not closed on strobe rise");

   frame_start_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_IDLE && sync_fall) |=> state_q == ST_FRAME && cnt_q == CNT_RST)
      else $error("frame not opened on strobe fall");

   idle_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_IDLE && !sync_fall) |=> state_q == ST_IDLE && $stable(sreg_q))
      else $error("shift register moved outside a frame");

   idle_chain_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      state_q == ST_IDLE |=> !DOUT)
      else $error("chain output active between frames");

   count_step_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && sclk_fall && !sync_rise && cnt_q != CNT_MAX)
      |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
      else $error("edge count did not step");

   // A wrapped count would turn a long chain frame into an abort
   count_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      (state_q == ST_FRAME && cnt_q == CNT_MAX) |=> cnt_q == CNT_MAX)
      else $error("edge count wrapped in a long frame");

   loaded_sticky_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      LOADED |=> LOADED)
      else $error("loaded flag dropped without reset");

   update_loaded_a: assert property (
      @(posedge CLK_SYS) disable iff (!RST_B)
      UPDATE |-> LOADED)
      else $error("update without loaded flag");

endmodule : serial_write_port

/* File: host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module host_model (
   input wire logic clk,
   output logic sclk,
   output logic sync_b,
   output logic din
);
   initial begin
      sclk = 1'b1;
      sync_b = 1'b1;
      din = 1'b1;
   end
   task wt();
      repeat (4) @(negedge clk);
   endtask : wt
   // Clock idles high; data line inverted once released so stale bits never pass
   task send(input logic [31:0] b, input int n);
      sync_b = 1'b0;
      wt();
      for (int i = n - 1; i >= 0; i--) begin
         din = b[i];
         wt();
         sclk = 1'b0;
         wt();
         sclk = 1'b1;
      end
      wt();
      sync_b = 1'b1;
      din = ~din;
      repeat (8) @(negedge clk);
   endtask : send
endmodule : host_model

/* File: serial_write_port_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module serial_write_port_tb;
   import serial_port_pkg::*;
   logic CLK_SYS = 1'b0;
   logic RST_B = 1'b0;
   logic SCLK, SYNC_B, DIN, DOUT, UPDATE, LOADED;
   logic [WORD_BITS-1:0] WORD;
   logic [31:0] dq;
   int bad_count = 0;
   int checked = 0;
   int upd_n = 0;
   always #12.5 CLK_SYS = ~CLK_SYS;
   host_model host_model_i (.clk(CLK_SYS), .sclk(SCLK), .sync_b(SYNC_B), .din(DIN));
   serial_write_port serial_write_port_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCLK(SCLK),
      .SYNC_B(SYNC_B), .DIN(DIN), .DOUT(DOUT), .WORD(WORD), .UPDATE(UPDATE), .LOADED(LOADED));
   always @(posedge CLK_SYS) if (UPDATE === 1'b1) upd_n++;
   // Chain output taken just before each new fall can reach it
   always @(negedge SCLK or posedge SYNC_B) dq = {dq[30:0], DOUT};
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task t_reset();
      check(WORD, WORD_RST);
      check({LOADED, DOUT}, 2'b00);
   endtask : t_reset
   task t_abort(input int n, input logic [15:0] w, input logic ld);
      int u;
      u = upd_n;
      host_model_i.send(32'h0000FFFF, n);
      check(upd_n, u);
      check(WORD, w);
      check(LOADED, ld);
   endtask : t_abort
   task t_write(input logic [31:0] b, input int n);
      int u;
      u = upd_n;
      dq = '0;
      host_model_i.send(b, n);
      check(upd_n, u + 1);
      check(WORD, b[15:0]);
      check(LOADED, 1'b1);
      check(dq, n > 16 ? {16'h0000, b[31:16]} : 32'h0);
      check(DOUT, 1'b0);
   endtask : t_write
   task t_rst_mid();
      int u;
      u = upd_n;
      RST_B = 1'b0;
      repeat (2) @(negedge CLK_SYS);
      check({WORD, LOADED, DOUT}, 18'h00000);
      RST_B = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      check(upd_n, u);
      t_reset();
   endtask : t_rst_mid
   task test_done();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      repeat (2) @(negedge CLK_SYS);
      RST_B = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      t_reset();
      t_abort(14, WORD_RST, 1'b0);
      t_write(32'h0000A5C3, 16);
      t_abort(15, 16'hA5C3, 1'b1);
      t_write(32'h3C96E10F, 32);
      t_rst_mid();
      t_abort(14, WORD_RST, 1'b0);
      t_write(32'h00005A3C, 16);
      test_done();
   end
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
endmodule : serial_write_port_tb
